// *** rtl/tsp_pkg.sv ***
// constants and types shared by the two-wire sensor slave port
package tsp_pkg;
    // clock and bus timeout
    localparam int unsigned TSP_CLK_HZ = 100_000_000;
    localparam int unsigned TSP_TIMEOUT_MS = 18;
    localparam int unsigned TSP_TIMEOUT_CYCLES = TSP_TIMEOUT_MS * (TSP_CLK_HZ / 1000);
    localparam int unsigned TSP_TO_W = $clog2(TSP_TIMEOUT_CYCLES + 1);

    // slave address, low two bits come from the address-select strap
    localparam logic [6:0] TSP_ADDR_BASE = 7'h48;
    localparam logic [7:0] TSP_HS_MASK = 8'hF8;
    localparam logic [7:0] TSP_HS_CODE = 8'h08;

    // pointer values
    localparam logic [7:0] TSP_PTR_RESET = 8'h00;
    localparam logic [7:0] TSP_PTR_SWRST = 8'h20;
    localparam logic [7:0] TSP_PTR_LOCK = 8'hC4;
    localparam logic [7:0] TSP_PTR_BLK_FIRST = 8'h80;
    localparam logic [7:0] TSP_PTR_BLK_LAST = 8'h88;
    localparam logic [3:0] TSP_CFG_NIBBLE = 4'h3;
    localparam int unsigned TSP_SWRST_BIT = 15;

    // write-lock keys and read-back values
    localparam logic [15:0] TSP_LOCK_KEY = 16'h5CA6;
    localparam logic [15:0] TSP_UNLOCK_KEY = 16'hEB19;
    localparam logic [15:0] TSP_LOCKED_RD = 16'h8000;
    localparam logic [15:0] TSP_UNLOCKED_RD = 16'h0000;
    localparam logic [15:0] TSP_ZERO16 = 16'h0000;

    // register store: index 0..15 protected bank 30h..3Fh, 16..24 result bank 80h..88h
    localparam int unsigned TSP_MEM_DEPTH = 32;
    localparam int unsigned TSP_IDX_W = 5;
    localparam logic [3:0] TSP_POR_CFG_IDX = 4'h0;
    localparam logic [3:0] TSP_POR_HYS_IDX = 4'h8;
    localparam logic [3:0] TSP_POR_LIM1_IDX = 4'h9;
    localparam logic [3:0] TSP_POR_LIM2_IDX = 4'hA;
    localparam logic [15:0] TSP_POR_CFG = 16'h0F9C;
    localparam logic [15:0] TSP_POR_HYS = 16'h0800;
    localparam logic [15:0] TSP_POR_LIM = 16'h7FC0;

    // bit and byte counts
    localparam logic [3:0] TSP_BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] TSP_PH_PTR = 2'h0;
    localparam logic [1:0] TSP_PH_MSB = 2'h1;
    localparam logic [1:0] TSP_PH_LSB = 2'h2;

    typedef enum logic [6:0] {
        TSP_IDLE = 7'h01,
        TSP_ADDR = 7'h02,
        TSP_ACK_ADDR = 7'h04,
        TSP_RX = 7'h08,
        TSP_ACK_RX = 7'h10,
        TSP_TX = 7'h20,
        TSP_ACK_TX = 7'h40
    } tsp_state_t;
endpackage

// *** rtl/tsp_mem_if.sv ***
// interface between the serial controller and its register store
`timescale 1ns/100ps
`default_nettype none
interface tsp_mem_if;
    logic init;
    logic wr_en;
    logic [tsp_pkg::TSP_IDX_W-1:0] wr_idx;
    logic [15:0] wr_data;
    logic res_en;
    logic [tsp_pkg::TSP_IDX_W-1:0] res_idx;
    logic [15:0] res_data;
    logic [tsp_pkg::TSP_IDX_W-1:0] rd_idx;
    logic [15:0] rd_data;
    modport ctrl (output init, wr_en, wr_idx, wr_data, res_en, res_idx, res_data, rd_idx, input rd_data);
    modport store (input init, wr_en, wr_idx, wr_data, res_en, res_idx, res_data, rd_idx, output rd_data);
endinterface
`default_nettype wire

// *** rtl/tsp_reg_store.sv ***
// register store with power-on defaults and registered read data
`timescale 1ns/100ps
`default_nettype none
module tsp_reg_store (
    input wire logic clock,
    input wire logic sys_rst,
    tsp_mem_if.store mem
);
    import tsp_pkg::*;

    logic [15:0] word [TSP_MEM_DEPTH];

    // default contents per index
    function automatic logic [15:0] por_value(input int unsigned i);
        logic [3:0] low;
        low = 4'(i);
        if (i >= 16) begin
            por_value = TSP_ZERO16;
        end else if (low == TSP_POR_CFG_IDX) begin
            por_value = TSP_POR_CFG;
        end else if (low == TSP_POR_HYS_IDX) begin
            por_value = TSP_POR_HYS;
        end else if (low == TSP_POR_LIM1_IDX || low == TSP_POR_LIM2_IDX) begin
            por_value = TSP_POR_LIM;
        end else begin
            por_value = TSP_ZERO16;
        end
    endfunction

    // storage: reset and init restore defaults, two write ports on disjoint banks
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < TSP_MEM_DEPTH; i++) begin
                word[i] <= por_value(i);
            end
        end else if (mem.init) begin
            for (int i = 0; i < TSP_MEM_DEPTH; i++) begin
                word[i] <= por_value(i);
            end
        end else begin
            if (mem.wr_en) begin
                word[mem.wr_idx] <= mem.wr_data;
            end
            if (mem.res_en) begin
                word[mem.res_idx] <= mem.res_data;
            end
        end
    end

    // read port
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mem.rd_data <= TSP_ZERO16;
        end else begin
            mem.rd_data <= word[mem.rd_idx];
        end
    end
endmodule
`default_nettype wire

// *** rtl/tsp_serial_port.sv ***
// two-wire slave port of the temperature sensor: framing, pointer, lock, timeout
// Notes on behaviour
// - data falling while clock high is START
// - data rising while clock high is STOP
// - first byte: seven address bits, direction bit
// - matching address acknowledged low in ninth pulse
// - each byte eight pulses plus receiver acknowledge
// - strap selects one of four addresses
// - pointer kept for later reads
// - sixteen-bit words, MSB first, master NACK ends
// - block 80h-88h auto-increments after each word, holds at 88h
// - stopped block read resumes at next register
// - bit 15 at 20h resets all registers
// - master code 0000 1xxx unacknowledged, enters high-speed
// - high-speed holds until STOP, then fast filters
// - clock up to 400kHz fast, 2.5MHz high-speed
// - 18ms clock low in frame resets interface
// - 5CA6h at C4h locks, EB19h unlocks
// - lock register reads 8000h locked, 0000h unlocked
// - locked registers ignore writes, still read
// - locked after power-up and software reset
`timescale 1ns/100ps
`default_nettype none
module tsp_serial_port #(
    parameter int unsigned TIMEOUT_CYCLES = tsp_pkg::TSP_TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_sel,
    input wire logic result_we,
    input wire logic [3:0] result_idx,
    input wire logic [15:0] result_data,
    output logic hs_mode,
    output logic locked,
    output logic conv_abort
);
    import tsp_pkg::*;

    tsp_mem_if mem ();

    logic scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
    logic [1:0] sel_m, sel_s;
    tsp_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift_in;
    logic [15:0] tx_shift;
    logic [7:0] ptr;
    logic [1:0] wr_phase;
    logic [7:0] wr_msb;
    logic is_read, half, master_ack, in_frame;
    logic mem_init, mem_wr;
    logic [TSP_IDX_W-1:0] wr_idx;
    logic [15:0] wr_data;
    logic [TSP_TO_W-1:0] to_cnt;

    // pointer decoding shared by read and write paths
    function automatic logic in_block(input logic [7:0] p);
        in_block = (p >= TSP_PTR_BLK_FIRST) && (p <= TSP_PTR_BLK_LAST);
    endfunction

    function automatic logic in_cfg(input logic [7:0] p);
        in_cfg = (p[7:4] == TSP_CFG_NIBBLE);
    endfunction

    function automatic logic [TSP_IDX_W-1:0] store_idx(input logic [7:0] p);
        store_idx = {in_block(p), p[3:0]};
    endfunction

    // pin synchronisers, third stage only for edge detection
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
            sel_m <= 2'h0;
            sel_s <= 2'h0;
        end else begin
            {scl_m, scl_s, scl_q} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_in, sda_m, sda_s};
            sel_m <= addr_sel;
            sel_s <= sel_m;
        end
    end

    // bus events and byte decoding
    wire scl_rise = scl_s & ~scl_q;
    wire scl_fall = ~scl_s & scl_q;
    wire start_seen = scl_s & scl_q & sda_q & ~sda_s;
    wire stop_seen = scl_s & scl_q & ~sda_q & sda_s;
    wire [6:0] own_addr = TSP_ADDR_BASE | {5'h00, sel_s};
    wire addr_hit = (shift_in[7:1] == own_addr);
    wire hs_code = ((shift_in & TSP_HS_MASK) == TSP_HS_CODE);
    wire byte_done = (bit_cnt == TSP_BITS_PER_BYTE);
    wire [15:0] commit_word = {wr_msb, shift_in};
    wire [7:0] next_ptr = (in_block(ptr) && ptr != TSP_PTR_BLK_LAST) ? ptr + 8'h01 : ptr;
    wire [15:0] lock_word = locked ? TSP_LOCKED_RD : TSP_UNLOCKED_RD;
    wire [15:0] read_word = (ptr == TSP_PTR_LOCK) ? lock_word :
                            (in_cfg(ptr) || in_block(ptr)) ? mem.rd_data : TSP_ZERO16;
    wire timeout_hit = in_frame & ~scl_s & (to_cnt == TSP_TO_W'(TIMEOUT_CYCLES - 1));

    // register store hookup
    assign mem.init = mem_init;
    assign mem.wr_en = mem_wr;
    assign mem.wr_idx = wr_idx;
    assign mem.wr_data = wr_data;
    assign mem.res_en = result_we;
    assign mem.res_idx = {1'b1, result_idx};
    assign mem.res_data = result_data;
    assign mem.rd_idx = store_idx(ptr);

    tsp_reg_store u_store (
        .clock(clock),
        .sys_rst(sys_rst),
        .mem(mem)
    );

    // clock-low timeout counter, only runs inside a frame
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            to_cnt <= '0;
        end else if (!in_frame || scl_s) begin
            to_cnt <= '0;
        end else begin
            to_cnt <= to_cnt + 1'b1;
        end
    end

    // serial protocol engine
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= TSP_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            tx_shift <= TSP_ZERO16;
            ptr <= TSP_PTR_RESET;
            wr_phase <= TSP_PH_PTR;
            wr_msb <= 8'h00;
            is_read <= 1'b0;
            half <= 1'b0;
            master_ack <= 1'b0;
            in_frame <= 1'b0;
            hs_mode <= 1'b0;
            locked <= 1'b1;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
            conv_abort <= 1'b0;
            mem_init <= 1'b0;
            mem_wr <= 1'b0;
            wr_idx <= '0;
            wr_data <= TSP_ZERO16;
        end else begin
            conv_abort <= 1'b0;
            mem_init <= 1'b0;
            mem_wr <= 1'b0;
            if (timeout_hit) begin
                state <= TSP_IDLE;
                sda_oe <= 1'b0;
                in_frame <= 1'b0;
            end else if (start_seen) begin
                state <= TSP_ADDR;
                bit_cnt <= 4'h0;
                sda_oe <= 1'b0;
                wr_phase <= TSP_PH_PTR;
                in_frame <= 1'b1;
            end else if (stop_seen) begin
                state <= TSP_IDLE;
                sda_oe <= 1'b0;
                in_frame <= 1'b0;
                hs_mode <= 1'b0;
            end else begin
                case (state)
                    TSP_ADDR: begin
                        if (scl_rise) begin
                            shift_in <= {shift_in[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            if (hs_code) begin
                                hs_mode <= 1'b1;
                                state <= TSP_IDLE;
                            end else if (addr_hit) begin
                                sda_oe <= 1'b1;
                                is_read <= shift_in[0];
                                state <= TSP_ACK_ADDR;
                            end else begin
                                state <= TSP_IDLE;
                            end
                        end
                    end
                    TSP_ACK_ADDR: begin
                        if (scl_fall) begin
                            bit_cnt <= 4'h0;
                            if (is_read) begin
                                half <= 1'b0;
                                sda_oe <= ~read_word[15];
                                tx_shift <= {read_word[14:0], 1'b0};
                                state <= TSP_TX;
                            end else begin
                                sda_oe <= 1'b0;
                                state <= TSP_RX;
                            end
                        end
                    end
                    TSP_RX: begin
                        if (scl_rise) begin
                            shift_in <= {shift_in[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && byte_done) begin
                            sda_oe <= 1'b1;
                            state <= TSP_ACK_RX;
                        end
                    end
                    TSP_ACK_RX: begin
                        if (scl_fall) begin
                            sda_oe <= 1'b0;
                            bit_cnt <= 4'h0;
                            state <= TSP_RX;
                            case (wr_phase)
                                TSP_PH_PTR: begin
                                    ptr <= shift_in;
                                    wr_phase <= TSP_PH_MSB;
                                end
                                TSP_PH_MSB: begin
                                    wr_msb <= shift_in;
                                    wr_phase <= TSP_PH_LSB;
                                end
                                default: begin
                                    wr_phase <= TSP_PH_MSB;
                                    if (ptr == TSP_PTR_SWRST) begin
                                        if (commit_word[TSP_SWRST_BIT]) begin
                                            mem_init <= 1'b1;
                                            conv_abort <= 1'b1;
                                            locked <= 1'b1;
                                            ptr <= TSP_PTR_RESET;
                                        end
                                    end else if (ptr == TSP_PTR_LOCK) begin
                                        if (commit_word == TSP_LOCK_KEY) begin
                                            locked <= 1'b1;
                                        end else if (commit_word == TSP_UNLOCK_KEY) begin
                                            locked <= 1'b0;
                                        end
                                    end else if (in_cfg(ptr) && !locked) begin
                                        mem_wr <= 1'b1;
                                        wr_idx <= store_idx(ptr);
                                        wr_data <= commit_word;
                                    end
                                end
                            endcase
                        end
                    end
                    TSP_TX: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall) begin
                            if (byte_done) begin
                                sda_oe <= 1'b0; // release for the master's acknowledge
                                state <= TSP_ACK_TX;
                            end else begin
                                sda_oe <= ~tx_shift[15];
                                tx_shift <= {tx_shift[14:0], 1'b0};
                            end
                        end
                    end
                    TSP_ACK_TX: begin
                        if (scl_rise) begin
                            master_ack <= ~sda_s;
                            if (half) begin
                                ptr <= next_ptr;
                            end
                        end else if (scl_fall) begin
                            if (!master_ack) begin
                                state <= TSP_IDLE;
                            end else begin
                                bit_cnt <= 4'h0;
                                half <= ~half;
                                state <= TSP_TX;
                                if (half) begin
                                    sda_oe <= ~read_word[15];
                                    tx_shift <= {read_word[14:0], 1'b0};
                                end else begin
                                    sda_oe <= ~tx_shift[15];
                                    tx_shift <= {tx_shift[14:0], 1'b0};
                                end
                            end
                        end
                    end
                    TSP_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    default: begin
                        state <= TSP_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/tsp_port_checker_assertions.sv ***
// assertion checker watching the pins of the two-wire sensor slave port
`timescale 1ns/100ps
`default_nettype none
module tsp_port_checker #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic [1:0] addr_sel,
    input wire logic result_we,
    input wire logic [3:0] result_idx,
    input wire logic [15:0] result_data,
    input wire logic hs_mode,
    input wire logic locked,
    input wire logic conv_abort
);
    logic sda_q;
    logic scl_q;
    logic in_frame;
    logic [3:0] stop_age;
    logic [31:0] low_cnt;
    wire logic start_pin = scl_in & scl_q & sda_q & ~sda_in;
    wire logic stop_pin = scl_in & scl_q & ~sda_q & sda_in;
    // frame tracking from pin levels, cycles since stop, clock-low length
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sda_q <= 1'b1;
            scl_q <= 1'b1;
            in_frame <= 1'b0;
            stop_age <= 4'hF;
            low_cnt <= 32'h0;
        end else begin
            sda_q <= sda_in;
            scl_q <= scl_in;
            in_frame <= start_pin | (in_frame & ~stop_pin);
            stop_age <= stop_pin ? 4'h0 : stop_age + {3'h0, stop_age != 4'hF};
            low_cnt <= scl_in ? 32'h0 : low_cnt + {31'h0, low_cnt != 32'hFFFFFFFF};
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_out_low; !sda_out; endproperty
    a_out_low: assert property (p_out_low) else $error("data pin driven high");
    property p_idle_quiet; !in_frame [*8] |-> !sda_oe; endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("data pulled outside a frame");
    property p_hs_noack; $rose(hs_mode) |-> !sda_oe [*8]; endproperty
    a_hs_noack: assert property (p_hs_noack) else $error("master code acknowledged");
    property p_hs_hold; $fell(hs_mode) |-> stop_age < 4'h8; endproperty
    a_hs_hold: assert property (p_hs_hold) else $error("fast mode left without stop");
    property p_abort_pulse; conv_abort |=> !conv_abort; endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than a cycle");
    property p_abort_locks; conv_abort |-> ##[0:2] locked; endproperty
    a_abort_locks: assert property (p_abort_locks) else $error("not locked after reset");
    property p_timeout; low_cnt == TIMEOUT_CYCLES + 8 |-> !sda_oe; endproperty
    a_timeout: assert property (p_timeout) else $error("data held after clock timeout");
    property p_lock_frame; $changed(locked) |-> in_frame; endproperty
    a_lock_frame: assert property (p_lock_frame) else $error("lock changed outside a frame");
endmodule
bind tsp_serial_port tsp_port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (.clock(clock),
    .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_sel(addr_sel), .result_we(result_we), .result_idx(result_idx), .result_data(result_data),
    .hs_mode(hs_mode), .locked(locked), .conv_abort(conv_abort));
`default_nettype wire

// *** tb/tsp_bus_master.sv ***
// two-wire bus master model, clock and open-drain data
`timescale 1ns/100ps
`default_nettype none
module tsp_bus_master (
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda
);
    logic in_frame;
    // idle bus: both lines released, clock stands still
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        in_frame = 1'b0;
    end
    // every line change lands on a falling clock edge
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one bit: 5 cycles low, 3 high, sampled before the fall, 80 ns
    task automatic bit_slot(input logic v, output logic r);
        scl = 1'b0;
        w(2);
        sda = v;
        w(3);
        scl = 1'b1;
        w(3);
        r = sda_line;
    endtask
    // repeated start first lets the slave release data
    task automatic start();
        logic r;
        if (in_frame) begin
            bit_slot(1'b1, r);
        end
        sda = 1'b0;
        w(3);
        in_frame = 1'b1;
    endtask
    task automatic stop();
        scl = 1'b0;
        w(2);
        sda = 1'b0;
        w(3);
        scl = 1'b1;
        w(3);
        sda = 1'b1;
        w(5);
        in_frame = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(b[i], r);
        end
        bit_slot(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] b, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, b[i]);
        end
        bit_slot(nack, r);
    endtask
    // slow master: clock held low for n cycles
    task automatic hold_low(input int n);
        scl = 1'b0;
        w(n);
    endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the two-wire sensor slave port
`timescale 1ns/100ps
`default_nettype none
module tb;
    import tsp_pkg::*;
    localparam int unsigned TO_CYC = 200;
    logic clock, sys_rst, scl, sda_m, sda_out, sda_oe, result_we, hs_mode, locked, conv_abort, a;
    logic [1:0] addr_sel;
    logic [3:0] result_idx;
    logic [15:0] result_data, w0, w1;
    logic [7:0] b;
    int n_errors = 0, checks = 0, n_abort = 0, n0;
    // pulled-up data wire, low while either side pulls
    wire logic sda_line = sda_m & ~sda_oe;
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    tsp_bus_master u_mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda(sda_m));
    tsp_serial_port #(.TIMEOUT_CYCLES(TO_CYC)) u_dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .result_we(result_we),
        .result_idx(result_idx), .result_data(result_data), .hs_mode(hs_mode), .locked(locked),
        .conv_abort(conv_abort));
    // count abort pulses
    always @(negedge clock) begin
        if (conv_abort === 1'b1) n_abort++;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [7:0] adr(input logic rd);
        return {7'h48 | {5'h00, addr_sel}, rd};
    endfunction
    function automatic logic [15:0] rv(input int i);
        return 16'hC030 + 16'h0101 * i[15:0];
    endfunction
    task automatic wa(input logic [7:0] v);
        u_mst.wbyte(v, a);
        chk("ack", 16'h0001, {15'h0000, a});
    endtask
    task automatic setp(input logic [7:0] p);
        u_mst.start();
        wa(adr(1'b0));
        wa(p);
    endtask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        setp(p);
        wa(d[15:8]);
        wa(d[7:0]);
        u_mst.stop();
    endtask
    // read one or two words in one frame, last byte not acknowledged
    task automatic rdk(input int n, output logic [15:0] x, output logic [15:0] y);
        logic [7:0] h, l;
        u_mst.start();
        wa(adr(1'b1));
        u_mst.rbyte(h, 1'b0);
        u_mst.rbyte(l, n == 1);
        x = {h, l};
        y = 16'h0000;
        if (n == 2) begin
            u_mst.rbyte(h, 1'b0);
            u_mst.rbyte(l, 1'b1);
            y = {h, l};
        end
        u_mst.stop();
    endtask
    task automatic rdw(input logic [7:0] p, input logic [15:0] exp, input string nm);
        setp(p);
        rdk(1, w0, w1);
        chk(nm, exp, w0);
    endtask
    task automatic t_strap();
        for (int s = 0; s < 4; s++) begin
            addr_sel = s[1:0];
            repeat (4) @(negedge clock);
            for (int k = 0; k < 4; k++) begin
                u_mst.start();
                u_mst.wbyte({7'h48 + 7'(k), 1'b0}, a);
                u_mst.stop();
                chk("strap ack", {15'h0000, k == s}, {15'h0000, a});
            end
        end
        addr_sel = 2'h1;
        $display("strap test done");
    endtask
    task automatic t_lock();
        chk("locked at reset", 16'h0001, {15'h0000, locked});
        rdw(8'hC4, 16'h8000, "lock read");
        wr(8'h30, 16'h1234);
        rdw(8'h30, 16'h0F9C, "locked write");
        wr(8'hC4, 16'hEB19);
        chk("unlocked", 16'h0000, {15'h0000, locked});
        rdw(8'hC4, 16'h0000, "unlock read");
        wr(8'h30, 16'h1234);
        rdw(8'h30, 16'h1234, "open write");
        wr(8'hC4, 16'h5CA6);
        chk("relocked", 16'h0001, {15'h0000, locked});
        $display("lock test done");
    endtask
    task automatic t_short();
        wr(8'hC4, 16'hEB19);
        setp(8'h38);
        wa(8'h55);
        u_mst.stop();
        rdw(8'h38, 16'h0800, "cut write");
        rdk(1, w0, w1);
        chk("kept pointer", 16'h0800, w0);
        $display("short write test done");
    endtask
    task automatic t_swrst();
        wr(8'h38, 16'h4321);
        rdw(8'h38, 16'h4321, "open write");
        n0 = n_abort;
        wr(8'h20, 16'h8000);
        chk("abort count", n0[15:0] + 16'h0001, n_abort[15:0]);
        chk("locked after reset", 16'h0001, {15'h0000, locked});
        rdw(8'h38, 16'h0800, "default 38");
        rdw(8'h30, 16'h0F9C, "default 30");
        $display("software reset test done");
    endtask
    task automatic t_block();
        for (int i = 0; i < 9; i++) begin
            result_we = 1'b1;
            result_idx = i[3:0];
            result_data = rv(i);
            @(negedge clock);
        end
        result_we = 1'b0;
        setp(8'h86);
        rdk(2, w0, w1);
        chk("block 86", rv(6), w0);
        chk("block 87", rv(7), w1);
        rdk(2, w0, w1);
        chk("resume 88", rv(8), w0);
        chk("hold 88", rv(8), w1);
        setp(8'h80);
        u_mst.start();
        wa(adr(1'b1));
        u_mst.rbyte(b, 1'b1);
        u_mst.stop();
        chk("single byte", rv(0) >> 8, {8'h00, b});
        rdk(1, w0, w1);
        chk("after single", rv(0), w0);
        $display("block read test done");
    endtask
    task automatic t_hs();
        u_mst.start();
        u_mst.wbyte(8'h0D, a);
        chk("code ack", 16'h0000, {15'h0000, a});
        chk("fast entry", 16'h0001, {15'h0000, hs_mode});
        u_mst.start();
        wa(adr(1'b0));
        chk("fast kept", 16'h0001, {15'h0000, hs_mode});
        u_mst.stop();
        repeat (8) @(negedge clock);
        chk("fast left", 16'h0000, {15'h0000, hs_mode});
        $display("high speed test done");
    endtask
    task automatic t_timeout();
        setp(8'h30);
        u_mst.start();
        wa(adr(1'b1));
        u_mst.hold_low(TO_CYC + 50);
        chk("released", 16'h0001, {15'h0000, sda_line});
        u_mst.stop();
        rdw(8'h30, 16'h0F9C, "after timeout");
        $display("timeout test done");
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        addr_sel = 2'h0;
        result_we = 1'b0;
        result_idx = 4'h0;
        result_data = 16'h0000;
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        repeat (10) @(negedge clock);
        t_strap();
        t_lock();
        t_short();
        t_swrst();
        t_block();
        t_hs();
        t_timeout();
        close_out();
    end
    // watchdog against a hung bus, about three times the expected run
    initial begin
        repeat (30000) @(posedge clock);
        n_errors++;
        close_out();
    end
endmodule
`default_nettype wire
